//--- rtl/ral_defines.svh
// Purpose: Constants for the register-to-accumulator load group
// Assumes: 10-bit instruction words, 4-bit data path
// Notes:   Included by the package and the design modules
`ifndef RAL_DEFINES_SVH
`define RAL_DEFINES_SVH

`define RAL_NIB_W          4
`define RAL_OP_W           10
`define RAL_NIB_ZERO       4'h0
`define RAL_OP_WAKE_ONE    10'h25a
`define RAL_OP_WAKE_TWO    10'h25b
`define RAL_OP_LCD_CTL     10'h24a
`define RAL_OP_CLOCK_CTL   10'h2d2
`define RAL_OP_PULLUP_ZERO 10'h2d8
`define RAL_OP_MEM_HI      6'h2c
`define RAL_OP_HI_MSB      9
`define RAL_OP_HI_LSB      4
`define RAL_IMM_MSB        3
`define RAL_IMM_LSB        0

`endif

//--- rtl/ral_pkg.sv
// Purpose: Types for the register-to-accumulator load group
// Assumes: ral_defines.svh gives the widths
// Notes:   Operation codes are internal to the block
`include "ral_defines.svh"

package ral_pkg;
	typedef logic [`RAL_NIB_W-1:0] ral_nib_t;
	typedef logic [`RAL_OP_W-1:0]  ral_word_t;
	typedef enum logic [2:0]
	{
		RAL_NONE        = 3'b000,
		RAL_WAKE_ONE    = 3'b001,
		RAL_WAKE_TWO    = 3'b010,
		RAL_LCD_CTL     = 3'b011,
		RAL_MEM_XOR     = 3'b100,
		RAL_CLOCK_CTL   = 3'b101,
		RAL_PULLUP_ZERO = 3'b110
	} ral_op_e;
endpackage : ral_pkg

//--- rtl/ral_decode.sv
// Purpose: Opcode recognition for the accumulator load group
// Assumes: Instruction word is stable while valid is high
// Notes:   Purely combinational
`timescale 1ns/1ps
`include "ral_defines.svh"

module ral_decode
(
	input  wire logic               instr_valid,
	input  wire ral_pkg::ral_word_t instr,
	output ral_pkg::ral_op_e        op
);
	import ral_pkg::*;

	always_comb
	begin
		op = RAL_NONE;
		if (instr_valid)
		begin
			if (instr[`RAL_OP_HI_MSB:`RAL_OP_HI_LSB] == `RAL_OP_MEM_HI)
				op = RAL_MEM_XOR;
			else if (instr == `RAL_OP_WAKE_ONE)
				op = RAL_WAKE_ONE;
			else if (instr == `RAL_OP_WAKE_TWO)
				op = RAL_WAKE_TWO;
			else if (instr == `RAL_OP_LCD_CTL)
				op = RAL_LCD_CTL;
			else if (instr == `RAL_OP_CLOCK_CTL)
				op = RAL_CLOCK_CTL;
			else if (instr == `RAL_OP_PULLUP_ZERO)
				op = RAL_PULLUP_ZERO;
		end
	end
endmodule : ral_decode

//--- rtl/ral_load_unit.sv
// Purpose: Executes loads from control registers and memory into the accumulator
// Assumes: Sources and memory data come from logic on clk_sys; mem_data is M(data_pointer)
// Notes:   Every load takes one cycle; carry and skip are never requested
`timescale 1ns/1ps
`include "ral_defines.svh"

module ral_load_unit
(
	input  wire logic               clk_sys,
	input  wire logic               rst,
	input  wire logic               instr_valid,
	input  wire ral_pkg::ral_word_t instr,
	input  wire ral_pkg::ral_nib_t  wake_ctl_one,
	input  wire ral_pkg::ral_nib_t  wake_ctl_two,
	input  wire ral_pkg::ral_nib_t  lcd_ctl_reg,
	input  wire ral_pkg::ral_nib_t  clock_ctl_reg,
	input  wire ral_pkg::ral_nib_t  pullup_ctl_zero,
	input  wire ral_pkg::ral_nib_t  mem_data,
	output ral_pkg::ral_nib_t       acc,
	output ral_pkg::ral_nib_t       x_reg,
	output logic                    load_done,
	output logic                    carry_we,
	output logic                    skip_req
);
	import ral_pkg::*;

	ral_op_e  op;
	ral_nib_t next_acc;
	ral_nib_t imm;

	// Opcode decoder
	ral_decode u_decode
	(
		.instr_valid (instr_valid),
		.instr       (instr),
		.op          (op)
	);

	assign imm = instr[`RAL_IMM_MSB:`RAL_IMM_LSB];

	// Memory-class opcode test, shared by the checks
	function automatic logic is_mem_word(input ral_word_t w);
		return w[`RAL_OP_HI_MSB:`RAL_OP_HI_LSB] == `RAL_OP_MEM_HI;
	endfunction : is_mem_word

	// Any opcode that this group answers
	function automatic logic is_group_word(input ral_word_t w);
		return is_mem_word(w)
			|| (w == `RAL_OP_WAKE_ONE)
			|| (w == `RAL_OP_WAKE_TWO)
			|| (w == `RAL_OP_LCD_CTL)
			|| (w == `RAL_OP_CLOCK_CTL)
			|| (w == `RAL_OP_PULLUP_ZERO);
	endfunction : is_group_word

	// Next accumulator value
	always_comb
	begin
		next_acc = acc;
		unique case (op)
			RAL_NONE:        next_acc = acc;
			RAL_WAKE_ONE:    next_acc = wake_ctl_one;
			RAL_WAKE_TWO:    next_acc = wake_ctl_two;
			RAL_LCD_CTL:     next_acc = lcd_ctl_reg;
			RAL_MEM_XOR:     next_acc = mem_data;
			RAL_CLOCK_CTL:   next_acc = clock_ctl_reg;
			RAL_PULLUP_ZERO: next_acc = pullup_ctl_zero;
			default:         next_acc = acc;
		endcase
	end

	// Accumulator
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			acc <= `RAL_NIB_ZERO;
		else
			acc <= next_acc;
	end

	// X register
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			x_reg <= `RAL_NIB_ZERO;
		else if (op == RAL_MEM_XOR)
			x_reg <= x_reg ^ imm;
	end

	// Completion and side effects
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			load_done <= 1'b0;
			carry_we  <= 1'b0;
			skip_req  <= 1'b0;
		end
		else
		begin
			load_done <= (op != RAL_NONE);
			carry_we  <= 1'b0;
			skip_req  <= 1'b0;
		end
	end

	// Opcode issue sequences
	sequence wake_one_issue_s;
		instr_valid && (instr == `RAL_OP_WAKE_ONE);
	endsequence

	sequence wake_two_issue_s;
		instr_valid && (instr == `RAL_OP_WAKE_TWO);
	endsequence

	sequence lcd_issue_s;
		instr_valid && (instr == `RAL_OP_LCD_CTL);
	endsequence

	sequence mem_issue_s;
		instr_valid && is_mem_word(instr);
	endsequence

	sequence clock_issue_s;
		instr_valid && (instr == `RAL_OP_CLOCK_CTL);
	endsequence

	sequence pullup_issue_s;
		instr_valid && (instr == `RAL_OP_PULLUP_ZERO);
	endsequence

	sequence group_issue_s;
		instr_valid && is_group_word(instr);
	endsequence

	sequence refused_issue_s;
		instr_valid && !is_group_word(instr);
	endsequence

	// Results one cycle after issue
	wake_two_a: assert property (@(posedge clk_sys) disable iff (rst)
		wake_two_issue_s |=> (acc == $past(wake_ctl_two)) && load_done)
		else $error("second wakeup load wrong");

	wake_two_flags_a: assert property (@(posedge clk_sys) disable iff (rst)
		wake_two_issue_s |=> !carry_we && !skip_req)
		else $error("second wakeup load touched flags");

	wake_one_a: assert property (@(posedge clk_sys) disable iff (rst)
		wake_one_issue_s |=> acc == $past(wake_ctl_one))
		else $error("first wakeup load wrong");

	wake_one_flags_a: assert property (@(posedge clk_sys) disable iff (rst)
		wake_one_issue_s |=> load_done && !carry_we && !skip_req)
		else $error("first wakeup load flags wrong");

	lcd_load_a: assert property (@(posedge clk_sys) disable iff (rst)
		lcd_issue_s |=> (acc == $past(lcd_ctl_reg)) && !skip_req)
		else $error("lcd load wrong");

	lcd_flags_a: assert property (@(posedge clk_sys) disable iff (rst)
		lcd_issue_s |=> load_done && !carry_we)
		else $error("lcd load flags wrong");

	mem_load_a: assert property (@(posedge clk_sys) disable iff (rst)
		mem_issue_s |=> acc == $past(mem_data))
		else $error("memory load wrong");

	mem_flags_a: assert property (@(posedge clk_sys) disable iff (rst)
		mem_issue_s |=> load_done && !carry_we && !skip_req)
		else $error("memory load flags wrong");

	x_xor_a: assert property (@(posedge clk_sys) disable iff (rst)
		mem_issue_s |=> x_reg == ($past(x_reg) ^ $past(imm)))
		else $error("x xor wrong");

	x_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
		!(instr_valid && is_mem_word(instr)) |=> $stable(x_reg))
		else $error("x changed without memory load");

	clock_load_a: assert property (@(posedge clk_sys) disable iff (rst)
		clock_issue_s |=> (acc == $past(clock_ctl_reg)) && !carry_we)
		else $error("clock control load wrong");

	clock_flags_a: assert property (@(posedge clk_sys) disable iff (rst)
		clock_issue_s |=> load_done && !skip_req)
		else $error("clock control load flags wrong");

	pullup_load_a: assert property (@(posedge clk_sys) disable iff (rst)
		pullup_issue_s |=> (acc == $past(pullup_ctl_zero)) && !skip_req)
		else $error("pull-up load wrong");

	pullup_flags_a: assert property (@(posedge clk_sys) disable iff (rst)
		pullup_issue_s |=> load_done && !carry_we)
		else $error("pull-up load flags wrong");

	group_done_a: assert property (@(posedge clk_sys) disable iff (rst)
		group_issue_s |=> load_done)
		else $error("recognised load gave no completion");

	// Refused words, idle cycles and reset
	refused_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
		refused_issue_s |=> $stable(acc) && $stable(x_reg) && !load_done)
		else $error("refused opcode changed state");

	acc_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
		!instr_valid |=> $stable(acc) && !load_done)
		else $error("accumulator changed when idle");

	reset_clear_a: assert property (@(posedge clk_sys)
		rst |=> (acc == `RAL_NIB_ZERO) && (x_reg == `RAL_NIB_ZERO) && !load_done && !carry_we && !skip_req)
		else $error("outputs not cleared by reset");
endmodule : ral_load_unit

//--- sim/test_register_to_accumulator_loads.sv
// Purpose: Self-checking bench for the accumulator load group
// Assumes: One-cycle answer, sources sampled in the issue cycle
// Notes:   Random stream from an LFSR seeded with 56336
`timescale 1ns/1ps
module test_register_to_accumulator_loads;
	import ral_pkg::*;
	logic      clk_sys = 1'b0;
	logic      rst = 1'b1;
	logic      instr_valid = 1'b0;
	ral_word_t instr = '0;
	ral_nib_t  src [6] = '{default: '0};
	ral_nib_t  acc;
	ral_nib_t  x_reg;
	logic      load_done;
	logic      carry_we;
	logic      skip_req;
	logic [15:0] lfsr = 16'hdc10;
	ral_word_t ops [5] = '{10'h25a, 10'h25b, 10'h24a, 10'h2d2, 10'h2d8};
	int        miscompares = 0;
	int        n_tests = 0;
	int        e_acc = 0;
	int        e_x = 0;
	int        e_done = 0;

	always #5 clk_sys = ~clk_sys;

	ral_load_unit DUT(.clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid), .instr(instr),
		.wake_ctl_one(src[0]), .wake_ctl_two(src[1]), .lcd_ctl_reg(src[2]), .clock_ctl_reg(src[3]),
		.pullup_ctl_zero(src[4]), .mem_data(src[5]), .acc(acc), .x_reg(x_reg),
		.load_done(load_done), .carry_we(carry_we), .skip_req(skip_req));

	function logic [15:0] step(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : step

	task chk(input string what, input logic [3:0] seen, input int exp);
		n_tests++;
		if (seen !== 4'(exp))
		begin
			$display("wrong value %s expected %h seen %h", what, 4'(exp), seen);
			miscompares++;
		end
	endtask : chk

	task complete_run;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run

	task check_all;
		chk("acc", acc, e_acc);
		chk("x_reg", x_reg, e_x);
		chk("load_done", {3'h0, load_done}, e_done);
		chk("carry_we", {3'h0, carry_we}, 0);
		chk("skip_req", {3'h0, skip_req}, 0);
	endtask : check_all

	initial
	begin
		repeat (3) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		for (int i = 0; i < 800; i++)
		begin
			check_all();
			for (int k = 0; k < 6; k++)
			begin
				lfsr = step(lfsr);
				src[k] = lfsr[3:0];
			end
			lfsr = step(lfsr);
			instr_valid = lfsr[2:0] != 3'h0;
			instr = lfsr[12:3];
			if (lfsr[15:13] < 3'h5)
				instr = ops[lfsr[15:13]];
			else if (lfsr[15:13] == 3'h5)
				instr[9:4] = 6'h2c;
			e_done = 0;
			if (instr_valid)
			begin
				for (int k = 0; k < 5; k++)
					if (instr == ops[k])
					begin
						e_acc = src[k];
						e_done = 1;
					end
				if (instr[9:4] == 6'h2c)
				begin
					e_acc = src[5];
					e_x = e_x ^ instr[3:0];
					e_done = 1;
				end
			end
			rst = (i == 400);
			if (rst)
			begin
				e_acc = 0;
				e_x = 0;
				e_done = 0;
			end
			@(posedge clk_sys);
			#1;
		end
		check_all();
		complete_run();
	end
endmodule : test_register_to_accumulator_loads
